// ==== dv/rps_rx_model.sv ====
// Receiver and battery detector seen from the control lines
`timescale 1ns/100ps
module rps_rx_model (
  input [4:0] rx_ctrl_lines,
  input [4:0] rx_ctrl_lines_oe_n,
  input batt_low,
  output [4:0] line_level,
  output low_battery_input
);
  // Floating lines fall to the pull-down, the receiver off level
  assign line_level = rx_ctrl_lines & ~rx_ctrl_lines_oe_n;
  assign low_battery_input = batt_low;
endmodule // rps_rx_model

// ==== dv/rps_seq_chk.sv ====
// Port assertions for the receiver power sequencer
`timescale 1ns/100ps
`include "rps_regs.vh"
module rps_seq_chk #(
  parameter [`RPS_PRE_W-1:0] MS_CYCLES = `RPS_MS_CYCLES
) (
  input clk,
  input srst,
  input decode_on,
  input [4:0] line_force_bit,
  input [4:0] off_pattern,
  input [4:0] warm_pattern0,
  input [4:0] sync3200_pattern,
  input [3:0] warm_en,
  input [8:0] poll_en,
  input rx_shutdown,
  input rate_3200,
  input sync_found,
  input low_battery_input,
  input [4:0] rx_ctrl_lines,
  input [4:0] rx_ctrl_lines_oe_n,
  input [3:0] rx_setting,
  input symbols_valid,
  input low_battery_level,
  input status_report_req,
  input batt_change_flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  float_hold_a: assert property (
    rx_ctrl_lines_oe_n == 5'h1F && line_force_bit == 5'h00 && !decode_on
    |=> rx_ctrl_lines_oe_n == 5'h1F) else $error("early drive");
  drive_hold_a: assert property (
    rx_ctrl_lines_oe_n == 5'h00 |=> rx_ctrl_lines_oe_n == 5'h00)
    else $error("lines released");
  turn_on_a: assert property (
    $rose(decode_on) && warm_en[0] |=> rx_setting == `RPS_SEL_W0
    && rx_ctrl_lines == warm_pattern0) else $error("bad turn-on");
  sync_pat_a: assert property (
    rx_setting == `RPS_SEL_S3200 |-> rx_ctrl_lines == sync3200_pattern)
    else $error("bad sync lines");
  shut_off_a: assert property (
    rx_shutdown && decode_on && $past(decode_on)
    && rx_setting != `RPS_SEL_OFF |=> rx_setting == `RPS_SEL_OFF
    && rx_ctrl_lines == off_pattern) else $error("bad shut-down");
  data_sel_a: assert property (
    sync_found && rate_3200 && symbols_valid && decode_on && !rx_shutdown
    && $past(decode_on) && rx_setting == `RPS_SEL_S3200
    |=> rx_setting == `RPS_SEL_D3200) else $error("bad data setting");
  lb_sample_a: assert property (
    rx_setting != $past(rx_setting) && poll_en[$past(rx_setting)]
    |-> low_battery_level == $past(low_battery_input))
    else $error("bad battery sample");
  report_a: assert property (
    $rose(status_report_req) |-> ##[0:1] batt_change_flag)
    else $error("report without flag");
  cover property (rx_setting == `RPS_SEL_D3200);
  cover property (rx_setting == `RPS_SEL_S1600);
  cover property (status_report_req);
endmodule // rps_seq_chk
bind rps_seq rps_seq_chk #(.MS_CYCLES(MS_CYCLES)) rps_seq_chk_inst (.*);

// ==== dv/rps_seq_tb.sv ====
// Self-checking bench for the receiver power sequencer
`timescale 1ns/100ps
module rps_seq_tb;
  reg clk = 0, srst = 1, decode_on = 0, rx_power_req = 0, rx_shutdown = 0;
  reg rate_3200 = 1, sync_found = 0, status_read = 0, batt_low = 0;
  reg [4:0] line_force_bit = 5'h00, off_pattern = 5'h03;
  reg [4:0] warm_pattern0 = 5'h11, warm_pattern1 = 5'h12;
  reg [4:0] warm_pattern2 = 5'h14, warm_pattern3 = 5'h18;
  reg [4:0] sync1600_pattern = 5'h05, sync3200_pattern = 5'h06;
  reg [4:0] data1600_pattern = 5'h09, data3200_pattern = 5'h0A;
  reg [3:0] warm_en = 4'h3;
  reg [7:0] off_time_ms = 8'h01, warm_time0_ms = 8'h01;
  reg [7:0] warm_time1_ms = 8'h02, warm_time2_ms = 8'h01;
  reg [7:0] warm_time3_ms = 8'h01, sync3200_warm_ms = 8'h01;
  reg [8:0] poll_en = 9'h006;
  wire [4:0] rx_ctrl_lines, rx_ctrl_lines_oe_n, line_level;
  wire [3:0] rx_setting;
  wire symbols_valid, low_battery_level, low_battery_input;
  wire batt_change_flag, status_report_req;
  integer errors = 0, n_compared = 0, n;
  // A 10-cycle millisecond keeps the 160 ms window short
  rps_seq #(.MS_CYCLES(18'h0_000A)) rps_seq_inst (.*);
  rps_rx_model rps_rx_model_inst (.*);
  always #2 clk = ~clk;
  task chk(input [7:0] got, input [7:0] exp);
  begin
    n_compared = n_compared + 1;
    if (got !== exp)
    begin
      errors = errors + 1;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  end
  endtask
  task step(input [3:0] s, input integer e, input integer t);
  begin
    n = 0;
    while (rx_setting !== s && n < 2000)
    begin
      @(negedge clk);
      n = n + 1;
    end
    chk(rx_setting, s);
    chk(n >= e - t && n <= e + t, 1'b1);
  end
  endtask
  task results;
  begin
    $display("%0d compared, %0d errors", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask
  initial
  begin
    #100000;
    errors = errors + 1;
    results;
  end
  initial
  begin
    repeat (10) @(negedge clk);
    srst = 0;
    @(negedge clk);
    chk(rx_ctrl_lines_oe_n, 5'h1F);
    chk(low_battery_level | batt_change_flag, 1'b0);
    line_force_bit = 5'h01;
    repeat (3) @(negedge clk);
    chk(rx_ctrl_lines_oe_n, 5'h1E);
    batt_low = 1;
    decode_on = 1;
    step(4'h1, 1, 0);
    chk(rx_ctrl_lines, 5'h11);
    step(4'h2, 10, 1);
    chk(low_battery_level, 1'b1);
    chk(line_level, 5'h12);
    batt_low = 0;
    step(4'h6, 20, 1);
    chk(low_battery_level, 1'b0);
    chk(status_report_req, 1'b1);
    repeat (2) @(negedge clk);
    chk(batt_change_flag, 1'b1);
    chk(status_report_req, 1'b0);
    chk(symbols_valid, 1'b0);
    repeat (12) @(negedge clk);
    chk(symbols_valid, 1'b1);
    status_read = 1;
    @(negedge clk);
    status_read = 0;
    @(negedge clk);
    chk(batt_change_flag, 1'b0);
    sync_found = 1;
    @(negedge clk);
    sync_found = 0;
    chk(rx_ctrl_lines, 5'h0A);
    rx_shutdown = 1;
    @(negedge clk);
    rx_shutdown = 0;
    chk(line_level, 5'h03);
    rate_3200 = 0;
    rx_power_req = 1;
    @(negedge clk);
    rx_power_req = 0;
    step(4'h1, 10, 1);
    step(4'h2, 10, 1);
    step(4'h5, 20, 1);
    sync_found = 1;
    @(negedge clk);
    sync_found = 0;
    chk(rx_ctrl_lines, 5'h09);
    rx_shutdown = 1;
    @(negedge clk);
    rx_shutdown = 0;
    warm_time1_ms = 8'hA0;
    rx_power_req = 1;
    @(negedge clk);
    rx_power_req = 0;
    step(4'h2, 22, 2);
    step(4'h0, 1580, 12);
    decode_on = 0;
    warm_en = 4'h0;
    repeat (2) @(negedge clk);
    chk(rx_ctrl_lines_oe_n, 5'h00);
    decode_on = 1;
    step(4'h6, 1, 0);
    decode_on = 0;
    line_force_bit = 5'h00;
    srst = 1;
    @(negedge clk);
    srst = 0;
    @(negedge clk);
    chk(rx_ctrl_lines_oe_n, 5'h1F);
    results;
  end
endmodule // rps_seq_tb

// ==== logic/rps_regs.vh ====
// Constants for the receiver power sequencer
`ifndef RPS_REGS_VH
`define RPS_REGS_VH
`define RPS_CLK_PERIOD_NS 4
`define RPS_MS_NS 1000000
// One millisecond of 4 ns clocks, sized to the 18-bit prescaler
`define RPS_MS_CYCLES 18'h3_D090
`define RPS_PRE_W 18
`define RPS_WARM_WIN_MS 8'hA0
`define RPS_MS_W 8
`define RPS_LINES 5
`define RPS_WARM_STEPS 4
`define RPS_SEL_W 4
`define RPS_SEL_OFF 4'h0
`define RPS_SEL_W0 4'h1
`define RPS_SEL_S1600 4'h5
`define RPS_SEL_S3200 4'h6
`define RPS_SEL_D1600 4'h7
`define RPS_SEL_D3200 4'h8
`define RPS_NSEL 9
`define RPS_LINES_RST 5'h00
`define RPS_OE_N_RST 5'h1F
`endif

// ==== logic/rps_seq.v ====
// Receiver power sequencer: control line settings, timing, battery poll
`timescale 1ns/100ps
`include "rps_regs.vh"

module rps_seq #(
  parameter [`RPS_PRE_W-1:0] MS_CYCLES = `RPS_MS_CYCLES
) (
  input wire clk,
  input wire srst,
  input wire decode_on,
  input wire [4:0] line_force_bit,
  input wire [4:0] off_pattern,
  input wire [4:0] warm_pattern0,
  input wire [4:0] warm_pattern1,
  input wire [4:0] warm_pattern2,
  input wire [4:0] warm_pattern3,
  input wire [4:0] sync1600_pattern,
  input wire [4:0] sync3200_pattern,
  input wire [4:0] data1600_pattern,
  input wire [4:0] data3200_pattern,
  input wire [3:0] warm_en,
  input wire [7:0] off_time_ms,
  input wire [7:0] warm_time0_ms,
  input wire [7:0] warm_time1_ms,
  input wire [7:0] warm_time2_ms,
  input wire [7:0] warm_time3_ms,
  input wire [7:0] sync3200_warm_ms,
  input wire [8:0] poll_en,
  input wire rx_power_req,
  input wire rx_shutdown,
  input wire rate_3200,
  input wire sync_found,
  input wire low_battery_input,
  input wire status_read,
  output wire [4:0] rx_ctrl_lines,
  output wire [4:0] rx_ctrl_lines_oe_n,
  output wire [3:0] rx_setting,
  output wire symbols_valid,
  output wire low_battery_level,
  output wire batt_change_flag,
  output wire status_report_req
);

  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_OFFW = 6'h02;
  localparam [5:0] ST_WARM = 6'h04;
  localparam [5:0] ST_SYNC = 6'h08;
  localparam [5:0] ST_DATA = 6'h10;
  localparam [5:0] ST_RXOFF = 6'h20;

  reg [5:0] st_q, st_d;
  reg [`RPS_SEL_W-1:0] sel_q, sel_d;
  reg [1:0] wi_q, wi_d;
  reg norm_q, norm_d, ld, win_ld, dec_q, drive_q;
  reg [7:0] dur, tmr_q, win_q;
  reg [4:0] lines_q, oe_n_q;
  reg [`RPS_PRE_W-1:0] pre_q, wpre_q;
  reg lb_q, have_smp_q, chg_q, rpt_q;
  wire tmr_done, win_done, dec_rise, leave, poll, differ;

  // Duration of warm-up step idx
  function [7:0] warm_time;
    input [1:0] idx;
    case (idx)
      2'd0: warm_time = warm_time0_ms;
      2'd1: warm_time = warm_time1_ms;
      2'd2: warm_time = warm_time2_ms;
      default: warm_time = warm_time3_ms;
    endcase
  endfunction

  // Pattern driven for a setting index
  function [4:0] pattern;
    input [`RPS_SEL_W-1:0] s;
    case (s)
      4'h1: pattern = warm_pattern0;
      4'h2: pattern = warm_pattern1;
      4'h3: pattern = warm_pattern2;
      4'h4: pattern = warm_pattern3;
      4'h5: pattern = sync1600_pattern;
      4'h6: pattern = sync3200_pattern;
      4'h7: pattern = data1600_pattern;
      4'h8: pattern = data3200_pattern;
      default: pattern = off_pattern;
    endcase
  endfunction

  // Sync setting for the current rate
  function [`RPS_SEL_W-1:0] sync_sel;
    input fast;
    sync_sel = fast ? `RPS_SEL_S3200 : `RPS_SEL_S1600;
  endfunction
  assign tmr_done = (tmr_q == 8'h00);
  assign win_done = (win_q == 8'h00);
  assign dec_rise = decode_on & ~dec_q;

  always @*
  begin
    st_d = st_q;
    sel_d = sel_q;
    wi_d = wi_q;
    norm_d = norm_q;
    ld = 1'b0;
    dur = 8'h00;
    win_ld = 1'b0;
    if (!decode_on)
    begin
      st_d = ST_IDLE;
      sel_d = `RPS_SEL_OFF;
      norm_d = 1'b0;
    end
    else if (dec_rise)
    begin
      norm_d = 1'b0;
      ld = 1'b1;
      if (warm_en[0])
      begin
        st_d = ST_WARM;
        wi_d = 2'd0;
        sel_d = `RPS_SEL_W0;
        dur = warm_time0_ms;
      end
      else
      begin
        st_d = ST_SYNC;
        sel_d = `RPS_SEL_S3200;
        dur = sync3200_warm_ms;
      end
    end
    else if (rx_shutdown && st_q != ST_RXOFF)
    begin
      st_d = ST_RXOFF;
      sel_d = `RPS_SEL_OFF;
      norm_d = 1'b0;
    end
    else
    begin
      case (st_q)
        ST_RXOFF:
        begin
          if (rx_power_req)
          begin
            st_d = ST_OFFW;
            sel_d = `RPS_SEL_OFF;
            norm_d = 1'b1;
            win_ld = 1'b1;
            ld = 1'b1;
            dur = off_time_ms;
          end
        end
        ST_OFFW, ST_WARM:
        begin
          if (norm_q && win_done)
          begin
            st_d = ST_RXOFF;
            sel_d = `RPS_SEL_OFF;
            norm_d = 1'b0;
          end
          else if (tmr_done)
          begin
            ld = 1'b1;
            if (st_q == ST_OFFW && warm_en[0])
            begin
              st_d = ST_WARM;
              wi_d = 2'd0;
              sel_d = `RPS_SEL_W0;
              dur = warm_time0_ms;
            end
            else if (st_q == ST_WARM && wi_q != 2'd3 && warm_en[wi_q + 2'd1])
            begin
              st_d = ST_WARM;
              wi_d = wi_q + 2'd1;
              sel_d = sel_q + 4'h1;
              dur = warm_time(wi_q + 2'd1);
            end
            else
            begin
              st_d = ST_SYNC;
              sel_d = norm_q ? sync_sel(rate_3200) : `RPS_SEL_S3200;
              dur = norm_q ? 8'h00 : sync3200_warm_ms;
            end
          end
        end
        ST_SYNC:
        begin
          if (sync_found)
          begin
            st_d = ST_DATA;
            sel_d = rate_3200 ? `RPS_SEL_D3200 : `RPS_SEL_D1600;
          end
          else if (sel_q != sync_sel(rate_3200) && tmr_done)
            sel_d = sync_sel(rate_3200);
        end
        ST_DATA: st_d = ST_DATA;
        default:
        begin
          st_d = ST_IDLE;
          sel_d = `RPS_SEL_OFF;
        end
      endcase
    end
  end

  // Any change of setting ends the old one
  assign leave = (sel_d != sel_q) | ld;
  assign poll = leave & poll_en[sel_q];
  assign differ = poll & have_smp_q & (low_battery_input != lb_q);
  always @(posedge clk)
  begin
    if (srst)
    begin
      st_q <= ST_IDLE;
      sel_q <= `RPS_SEL_OFF;
      wi_q <= 2'd0;
      norm_q <= 1'b0;
      dec_q <= 1'b0;
      drive_q <= 1'b0;
      lines_q <= `RPS_LINES_RST;
      oe_n_q <= `RPS_OE_N_RST;
    end
    else
    begin
      st_q <= (st_q == ST_IDLE && decode_on && !dec_rise) ? ST_RXOFF : st_d;
      sel_q <= sel_d;
      wi_q <= wi_d;
      norm_q <= norm_d;
      dec_q <= decode_on;
      drive_q <= drive_q | decode_on;
      lines_q <= pattern(sel_d);
      oe_n_q <= ~(line_force_bit | {5{drive_q | decode_on}});
    end
  end

  // Setting timer and warm-up window; host must fit warm-up in the window
  always @(posedge clk)
  begin
    if (srst)
    begin
      pre_q <= {`RPS_PRE_W{1'b0}};
      tmr_q <= 8'h00;
      wpre_q <= {`RPS_PRE_W{1'b0}};
      win_q <= 8'h00;
    end
    else
    begin
      if (ld)
      begin
        pre_q <= {`RPS_PRE_W{1'b0}};
        tmr_q <= dur;
      end
      else if (!tmr_done)
      begin
        if (pre_q == MS_CYCLES - 1'b1)
        begin
          pre_q <= {`RPS_PRE_W{1'b0}};
          tmr_q <= tmr_q - 8'h01;
        end
        else
          pre_q <= pre_q + 1'b1;
      end
      if (win_ld || dec_rise)
      begin
        wpre_q <= {`RPS_PRE_W{1'b0}};
        win_q <= win_ld ? `RPS_WARM_WIN_MS : 8'h00;
      end
      else if (!win_done)
      begin
        if (wpre_q == MS_CYCLES - 1'b1)
        begin
          wpre_q <= {`RPS_PRE_W{1'b0}};
          win_q <= win_q - 8'h01;
        end
        else
          wpre_q <= wpre_q + 1'b1;
      end
    end
  end

  // Battery poll; a new change wins over a clear in the same cycle
  always @(posedge clk)
  begin
    if (srst)
    begin
      lb_q <= 1'b0;
      have_smp_q <= 1'b0;
      chg_q <= 1'b0;
      rpt_q <= 1'b0;
    end
    else
    begin
      rpt_q <= differ;
      if (poll)
      begin
        lb_q <= low_battery_input;
        have_smp_q <= 1'b1;
      end
      if (differ)
        chg_q <= 1'b1;
      else if (status_read)
        chg_q <= 1'b0;
    end
  end

  assign rx_ctrl_lines = lines_q;
  assign rx_ctrl_lines_oe_n = oe_n_q;
  assign rx_setting = sel_q;
  // Decode settings only after both sync settle and window have run out
  assign symbols_valid = (st_q == ST_SYNC || st_q == ST_DATA) && tmr_done &&
    win_done;
  assign low_battery_level = lb_q;
  assign batt_change_flag = chg_q;
  assign status_report_req = rpt_q;

endmodule // rps_seq
